// >>> rtl/vpsc_pkg.sv
// Purpose : shared constants and state types of the backplane pin-side control
// Assumes : system clock clk_i at 125 MHz, reference clock pin at 64 MHz
// Notes   : address-modifier fields follow the standard space/privilege/cycle layout
package vpsc_pkg;

  // reference clock and address setup, counted in reference periods
  localparam int unsigned REF_PERIOD_PS  = 15625;
  localparam int unsigned ADDR_SETUP_NS  = 35;
  localparam int unsigned ADDR_SETUP_REF = (ADDR_SETUP_NS * 1000 + REF_PERIOD_PS - 1) / REF_PERIOD_PS;
  localparam int unsigned SETUP_CNT_W    = 4;

  // address space selector
  localparam logic [1:0] SPACE_A16 = 2'h0;
  localparam logic [1:0] SPACE_A24 = 2'h1;
  localparam logic [1:0] SPACE_A32 = 2'h2;

  // cycle type selector
  localparam logic [1:0] CYC_SINGLE = 2'h0;
  localparam logic [1:0] CYC_BLOCK  = 2'h1;
  localparam logic [1:0] CYC_MBLT   = 2'h2;

  // modifier code fields: upper three bits select the space
  localparam logic [2:0] AM_HI_A16  = 3'h5;
  localparam logic [2:0] AM_HI_A24  = 3'h7;
  localparam logic [2:0] AM_HI_A32  = 3'h1;
  localparam logic [1:0] AM_LO_DATA = 2'h1;
  localparam logic [1:0] AM_LO_PROG = 2'h2;
  localparam logic [1:0] AM_LO_BLT  = 2'h3;
  localparam logic [1:0] AM_LO_MBLT = 2'h0;

  // reset values of the pin drivers
  localparam logic [3:0] GRANT_IDLE_N = 4'hf;

  typedef enum logic [1:0] {
    GR_IDLE = 2'b00,
    GR_PASS = 2'b01,
    GR_OWN  = 2'b10,
    GR_DONE = 2'b11
  } vpsc_grant_st_t;

  typedef enum logic [1:0] {
    MS_IDLE   = 2'b00,
    MS_SETUP  = 2'b01,
    MS_STROBE = 2'b10
  } vpsc_mst_st_t;

endpackage

// >>> rtl/vpsc_sync.sv
// Purpose : two-stage synchroniser for a vector of backplane pins
// Assumes : each bit is sampled on its own; no bus coherency is implied
// Notes   : the first stage feeds only the second
`timescale 1ns/1ps
module vpsc_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] data_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] data_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;

  always_comb begin
    meta_d = data_i ^ reset_val_i;
  end

  // reset loads zero; reset_val_i is folded in on entry and undone at the output
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= meta_q;
    end
  end

  assign data_o = sync_q ^ reset_val_i;

endmodule

// >>> rtl/vpsc_top.sv
// Purpose : pin-side control of the backplane end of a host-to-backplane bridge
// Assumes : one clock; every backplane pin and the reference clock pass two flip-flops
// Notes   : data strobes, transfer acknowledge and the host side live elsewhere
// Functional notes
// R1 - fixed backplane timings are counted in edges of the 64 MHz reference clock
// R2 - backplane state machines advance only on reference clock edges; the code waits for them only in the address setup count
// R3 - in multiplexed block transfers address lines carry data bits 63 to 33
// R4 - in interrupt acknowledge the three low address lines carry the level
// R5 - address direction high while driving address and longword, else low
// R6 - six modifier lines encode space, privilege, cycle type and program/data
// R7 - modifier direction high while driving the codes, low while receiving
// R8 - address valid before strobe falls; receivers latch address on the fall
// R9 - strobe stays asserted across both phases of read-modify-write
// R10 - strobe direction high while driving the strobe, low while receiving
// R11 - as system controller assert bus clear when a higher request is pending
// R12 - the current owner releases the bus when bus clear is asserted; the code has no bus clear input and leaves GR_OWN only on mst_end
// R13 - the arbiter grants by driving one of four grant lines low
// R14 - accept a grant at our requested level, otherwise pass it onward
// R15 - at most one grant output asserted, the level being granted
// R16 - data direction high while driving data lines, low while receiving
// R17 - all direction outputs low when neither master nor responding slave
`timescale 1ns/1ps
module vpsc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        vme_reference_clock_i,
  input  wire logic        syscon_i,
  input  wire logic        mst_req_i,
  input  wire logic [1:0]  mst_level_i,
  input  wire logic [31:1] mst_addr_i,
  input  wire logic        mst_longword_n_i,
  input  wire logic [1:0]  mst_space_i,
  input  wire logic        mst_super_i,
  input  wire logic [1:0]  mst_cycle_i,
  input  wire logic        mst_program_i,
  input  wire logic        mst_write_i,
  input  wire logic        mst_rmw_i,
  input  wire logic [30:0] mst_mblt_hi_i,
  input  wire logic        mst_iack_i,
  input  wire logic [2:0]  mst_iack_level_i,
  input  wire logic        mst_phase_done_i,
  input  wire logic        mst_last_i,
  output logic             mst_owner_o,
  output logic             mst_strobe_o,
  input  wire logic        slv_select_i,
  input  wire logic        slv_read_i,
  output logic [31:1]      rx_addr_o,
  output logic [5:0]       rx_am_o,
  output logic             rx_valid_o,
  input  wire logic [31:1] backplane_address_lines_i,
  output logic [31:1]      backplane_address_lines_o,
  output logic             backplane_address_lines_oe_o,
  output logic             longword_n_o,
  output logic             longword_n_oe_o,
  input  wire logic [5:0]  address_modifier_lines_i,
  output logic [5:0]       address_modifier_lines_o,
  output logic             address_modifier_lines_oe_o,
  input  wire logic        address_strobe_n_i,
  output logic             address_strobe_n_o,
  output logic             address_strobe_n_oe_o,
  output logic             address_xcvr_direction_o,
  output logic             modifier_xcvr_direction_o,
  output logic             strobe_xcvr_direction_o,
  output logic             data_xcvr_direction_o,
  output logic             bus_clear_n_o,
  input  wire logic [3:0]  grant_in_n_i,
  output logic [3:0]       grant_out_n_o,
  input  wire logic [3:0]  bus_request_n_i,
  input  wire logic        bus_busy_n_i
);

  ////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  logic        rst_meta_q;
  logic        rst_q;
  logic [48:0] pin_s;
  logic        ref_s;
  logic        ref_prev_q;
  logic        ref_tick;
  logic        syscon_s;
  logic        as_n_s;
  logic        as_prev_q;
  logic        busy_n_s;
  logic [3:0]  req_n_s;
  logic [3:0]  gin_n_s;
  logic [5:0]  am_s;
  logic [31:1] addr_s;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta_q <= 1'b0;
      rst_q      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_q      <= rst_meta_q;
    end
  end

  // strobe, busy, requests and grants idle high, so their reset image is inverted
  vpsc_sync #(.WIDTH(49)) u_pins (
    .clk_i       (clk_i),
    .rst_n_i     (rst_q),
    .data_i      ({vme_reference_clock_i, syscon_i, address_strobe_n_i, bus_busy_n_i, bus_request_n_i,
                   grant_in_n_i, address_modifier_lines_i, backplane_address_lines_i}),
    .reset_val_i ({1'h0, 1'h0, 1'h1, 1'h1, 4'hf, 4'hf, 6'h00, 31'h0}),
    .data_o      (pin_s)
  );

  assign {ref_s, syscon_s, as_n_s, busy_n_s, req_n_s, gin_n_s, am_s, addr_s} = pin_s;
  assign ref_tick = ref_s & ~ref_prev_q; // R1

  ////////////////////////////////////////////////////////////////////////////////
  // grant daisy chain and bus clear

  vpsc_pkg::vpsc_grant_st_t gr_q;
  vpsc_pkg::vpsc_grant_st_t gr_d;
  logic [1:0] gr_lvl_q;
  logic [1:0] gr_lvl_d;
  logic [3:0] gout_n_q;
  logic [3:0] gout_n_d;
  logic [1:0] own_lvl_q;
  logic [1:0] own_lvl_d;
  logic       bclr_n_q;
  logic       bclr_n_d;
  logic       gin_any;
  logic [1:0] gin_lvl;
  logic       req_higher;
  logic       mst_end;

  always_comb begin
    gin_any = 1'b0;
    gin_lvl = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (!gin_n_s[i]) begin
        gin_any = 1'b1;
        gin_lvl = 2'(i);
      end
    end
    req_higher = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (!req_n_s[i] && 2'(i) > own_lvl_q) begin
        req_higher = 1'b1;
      end
    end
  end

  always_comb begin
    gr_d      = gr_q;
    gr_lvl_d  = gr_lvl_q;
    gout_n_d  = vpsc_pkg::GRANT_IDLE_N;
    own_lvl_d = gin_any ? gin_lvl : own_lvl_q;
    // limitation: owner level is taken from the grant seen here, not a full arbiter
    bclr_n_d  = ~(syscon_s & ~busy_n_s & req_higher); // R11
    unique case (gr_q)
      vpsc_pkg::GR_IDLE: begin
        if (gin_any) begin
          gr_lvl_d = gin_lvl;
          if (mst_req_i && mst_level_i == gin_lvl) begin
            gr_d = vpsc_pkg::GR_OWN; // R14
          end else begin
            gr_d = vpsc_pkg::GR_PASS;
            gout_n_d[gin_lvl] = 1'b0; // R14 R15
          end
        end
      end
      vpsc_pkg::GR_PASS: begin
        if (gin_n_s[gr_lvl_q]) begin
          gr_d = vpsc_pkg::GR_IDLE;
        end else begin
          gout_n_d[gr_lvl_q] = 1'b0; // R15
        end
      end
      vpsc_pkg::GR_OWN: begin
        if (mst_end) begin
          gr_d = vpsc_pkg::GR_DONE;
        end
      end
      vpsc_pkg::GR_DONE: begin
        // a grant still held low must not be passed on after our own tenure
        if (gin_n_s[gr_lvl_q]) begin
          gr_d = vpsc_pkg::GR_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      gr_q       <= vpsc_pkg::GR_IDLE;
      gr_lvl_q   <= 2'h0;
      gout_n_q   <= vpsc_pkg::GRANT_IDLE_N;
      own_lvl_q  <= 2'h0;
      bclr_n_q   <= 1'b1;
      ref_prev_q <= 1'b0;
    end else begin
      gr_q       <= gr_d;
      gr_lvl_q   <= gr_lvl_d;
      gout_n_q   <= gout_n_d;
      own_lvl_q  <= own_lvl_d;
      bclr_n_q   <= bclr_n_d;
      ref_prev_q <= ref_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // master address phase

  vpsc_pkg::vpsc_mst_st_t ms_q;
  vpsc_pkg::vpsc_mst_st_t ms_d;
  logic [vpsc_pkg::SETUP_CNT_W-1:0] cnt_q;
  logic [vpsc_pkg::SETUP_CNT_W-1:0] cnt_d;
  logic        phase_q;
  logic        phase_d;
  logic [31:1] addr_q;
  logic [31:1] addr_d;
  logic [5:0]  am_q;
  logic [5:0]  am_d;
  logic        lword_q;
  logic        lword_d;
  logic        write_q;
  logic        write_d;
  logic [2:0]  am_hi;
  logic [1:0]  am_lo;

  always_comb begin
    unique case (mst_space_i)
      vpsc_pkg::SPACE_A16: am_hi = vpsc_pkg::AM_HI_A16;
      vpsc_pkg::SPACE_A24: am_hi = vpsc_pkg::AM_HI_A24;
      default:             am_hi = vpsc_pkg::AM_HI_A32;
    endcase
    unique case (mst_cycle_i)
      vpsc_pkg::CYC_BLOCK: am_lo = vpsc_pkg::AM_LO_BLT;
      vpsc_pkg::CYC_MBLT:  am_lo = vpsc_pkg::AM_LO_MBLT;
      default:             am_lo = mst_program_i ? vpsc_pkg::AM_LO_PROG : vpsc_pkg::AM_LO_DATA;
    endcase
  end

  assign mst_end = (ms_q == vpsc_pkg::MS_STROBE) & mst_phase_done_i & mst_last_i & (phase_q | ~mst_rmw_i); // R9

  always_comb begin
    ms_d    = ms_q;
    cnt_d   = cnt_q;
    phase_d = phase_q;
    addr_d  = addr_q;
    am_d    = am_q;
    lword_d = lword_q;
    write_d = write_q;
    unique case (ms_q)
      vpsc_pkg::MS_IDLE: begin
        if (gr_q == vpsc_pkg::GR_OWN) begin
          ms_d    = vpsc_pkg::MS_SETUP;
          cnt_d   = '0;
          phase_d = 1'b0;
          addr_d  = mst_addr_i;
          if (mst_iack_i) begin
            addr_d[3:1] = mst_iack_level_i; // R4
          end
          am_d    = {am_hi, mst_super_i, am_lo}; // R6
          lword_d = mst_longword_n_i;
          write_d = mst_write_i;
        end
      end
      vpsc_pkg::MS_SETUP: begin
        // address is already on the pins; the strobe waits a whole setup in reference edges
        if (ref_tick) begin
          if (cnt_q == vpsc_pkg::SETUP_CNT_W'(vpsc_pkg::ADDR_SETUP_REF - 1)) begin
            ms_d = vpsc_pkg::MS_STROBE; // R1 R2 R8
          end else begin
            cnt_d = cnt_q + 1'b1;
          end
        end
      end
      vpsc_pkg::MS_STROBE: begin
        if (mst_phase_done_i) begin
          phase_d = 1'b1;
          if (am_q[1:0] == vpsc_pkg::AM_LO_MBLT) begin
            addr_d = mst_mblt_hi_i; // R3
          end
        end
        if (mst_end) begin
          ms_d = vpsc_pkg::MS_IDLE;
        end
      end
      default: begin
        ms_d = vpsc_pkg::MS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      ms_q    <= vpsc_pkg::MS_IDLE;
      cnt_q   <= '0;
      phase_q <= 1'b0;
      addr_q  <= '0;
      am_q    <= 6'h00;
      lword_q <= 1'b1;
      write_q <= 1'b0;
    end else begin
      ms_q    <= ms_d;
      cnt_q   <= cnt_d;
      phase_q <= phase_d;
      addr_q  <= addr_d;
      am_q    <= am_d;
      lword_q <= lword_d;
      write_q <= write_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // receive latch for the responding slave

  logic        rx_valid_q;
  logic        rx_valid_d;
  logic [31:1] rx_addr_q;
  logic [31:1] rx_addr_d;
  logic [5:0]  rx_am_q;
  logic [5:0]  rx_am_d;

  always_comb begin
    rx_valid_d = rx_valid_q & ~as_n_s;
    rx_addr_d  = rx_addr_q;
    rx_am_d    = rx_am_q;
    if (!as_n_s && as_prev_q && ms_q == vpsc_pkg::MS_IDLE) begin
      rx_valid_d = 1'b1; // R8
      rx_addr_d  = addr_s;
      rx_am_d    = am_s;
    end
  end

  always_ff @(posedge clk_i or negedge rst_q) begin
    if (!rst_q) begin
      rx_valid_q <= 1'b0;
      rx_addr_q  <= '0;
      rx_am_q    <= 6'h00;
      as_prev_q  <= 1'b1;
    end else begin
      rx_valid_q <= rx_valid_d;
      rx_addr_q  <= rx_addr_d;
      rx_am_q    <= rx_am_d;
      as_prev_q  <= as_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins and transceiver directions

  logic drive_addr;

  assign drive_addr                   = ms_q != vpsc_pkg::MS_IDLE;
  assign backplane_address_lines_o    = addr_q;
  assign backplane_address_lines_oe_o = drive_addr;
  assign longword_n_o                 = lword_q;
  assign longword_n_oe_o              = drive_addr;
  assign address_modifier_lines_o     = am_q;
  assign address_modifier_lines_oe_o  = drive_addr;
  assign address_strobe_n_o           = ms_q != vpsc_pkg::MS_STROBE; // R9
  assign address_strobe_n_oe_o        = drive_addr;
  assign address_xcvr_direction_o     = drive_addr; // R5 R17
  assign modifier_xcvr_direction_o    = drive_addr; // R7 R17
  assign strobe_xcvr_direction_o      = drive_addr; // R10 R17
  assign data_xcvr_direction_o        = (drive_addr & write_q) | (slv_select_i & slv_read_i & ~drive_addr); // R16 R17
  assign bus_clear_n_o                = bclr_n_q;
  assign grant_out_n_o                = gout_n_q;
  assign mst_owner_o                  = gr_q == vpsc_pkg::GR_OWN;
  assign mst_strobe_o                 = ms_q == vpsc_pkg::MS_STROBE;
  assign rx_addr_o                    = rx_addr_q;
  assign rx_am_o                      = rx_am_q;
  assign rx_valid_o                   = rx_valid_q;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_q);

  sequence s_setup_done;
    ms_q == vpsc_pkg::MS_SETUP && ref_tick && cnt_q == vpsc_pkg::SETUP_CNT_W'(vpsc_pkg::ADDR_SETUP_REF - 1);
  endsequence
  sequence s_rmw_first;
    ms_q == vpsc_pkg::MS_STROBE && mst_rmw_i && !phase_q && mst_phase_done_i;
  endsequence

  a_gout_onehot: assert property ($countones(~grant_out_n_o) <= 1) // R15
    else $error("more than one grant output asserted");
  a_grant_accept: assert property (gr_q == vpsc_pkg::GR_IDLE && gin_any && mst_req_i && mst_level_i == gin_lvl
    |=> grant_out_n_o == 4'hf && mst_owner_o ##1 drive_addr) // R14
    else $error("accepted grant passed on or not owned");
  a_grant_pass: assert property (gr_q == vpsc_pkg::GR_IDLE && gin_any && !(mst_req_i && mst_level_i == gin_lvl)
    |=> !grant_out_n_o[$past(gin_lvl)] && !mst_owner_o) // R14
    else $error("grant not passed at its level");
  a_bclr_cause: assert property (!bus_clear_n_o |-> $past(syscon_s && !busy_n_s && req_higher)) // R11
    else $error("bus clear without higher pending request");
  a_strobe_setup: assert property ($fell(address_strobe_n_o) |-> $past(ms_q) == vpsc_pkg::MS_SETUP
    && $past(backplane_address_lines_oe_o, 2)) // R8
    else $error("strobe fell without address setup");
  a_ref_pace: assert property (s_setup_done |=> address_strobe_n_o == 1'b0) // R1
    else $error("setup count did not release strobe");
  a_ref_only: assert property (ms_q == vpsc_pkg::MS_SETUP && !ref_tick |=> ms_q == vpsc_pkg::MS_SETUP
    && $stable(cnt_q)) // R2
    else $error("setup advanced without reference edge");
  a_rmw_hold: assert property (s_rmw_first |=> !address_strobe_n_o [*2]) // R9
    else $error("strobe released inside read-modify-write");
  a_iack_level: assert property (ms_q == vpsc_pkg::MS_IDLE && gr_q == vpsc_pkg::GR_OWN && mst_iack_i
    |=> backplane_address_lines_o[3:1] == $past(mst_iack_level_i)) // R4
    else $error("acknowledge level not on low address lines");
  a_mblt_data: assert property (ms_q == vpsc_pkg::MS_STROBE && mst_phase_done_i && am_q[1:0] == 2'h0
    |=> backplane_address_lines_o == $past(mst_mblt_hi_i)) // R3
    else $error("upper data not on address lines");
  a_am_a32sp: assert property (ms_q == vpsc_pkg::MS_IDLE && gr_q == vpsc_pkg::GR_OWN && mst_space_i == 2'h2
    && mst_super_i && mst_program_i && mst_cycle_i == 2'h0 |=> address_modifier_lines_o == 6'h0e) // R6
    else $error("wrong modifier code");
  a_dir_idle: assert property (!drive_addr && !slv_select_i |-> !address_xcvr_direction_o
    && !modifier_xcvr_direction_o && !strobe_xcvr_direction_o && !data_xcvr_direction_o) // R17
    else $error("direction high while idle");
  a_dir_drive: assert property (drive_addr |-> address_xcvr_direction_o && modifier_xcvr_direction_o
    && strobe_xcvr_direction_o && data_xcvr_direction_o == write_q) // R5 R7 R10 R16
    else $error("direction does not follow drive");

endmodule

// >>> sim/vme_pin_side_control_tb.sv
// Purpose : self-checking bench of the backplane pin-side control
// Assumes : partner model on the backplane; 64 MHz reference made here
// Notes   : random fields from a fixed seed, corner cases by hand
`timescale 1ns/1ps
module vme_pin_side_control_tb;
  logic        clk_i = 1'b0;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        syscon = '0, mreq = '0, mlw = '0, msup = '0, mprog = '0, mwr = '0, mrmw = '0, miack = '0;
  logic        mdone = '0, mlast = '0, ssel = '0, srd = '0, g_on = '0, r_on = '0, b_on = '0, f_go = '0;
  logic [1:0]  mlvl = '0, mspace = '0, mcyc = '0, g_lvl = '0, r_lvl = '0;
  logic [2:0]  milvl = '0;
  logic [30:0] mhi = '0;
  logic [31:1] maddr = '0, f_addr = '0, rxa, a_o, bp_a, a_bus;
  logic [5:0]  f_am = '0, rxam, am_o, bp_am, am_bus;
  logic [3:0]  gin_n, gout_n, req_n;
  logic        owner, strb, rxv, a_oe, lw, lw_oe, am_oe, s_o, s_oe, adir, mdir, sdir, ddir, bclr_n, busy_n;
  logic        bp_s, s_bus;
  logic [63:0] r;
  int          err_count = 0;
  int          check_count = 0;
  int          seed = 32'ha3ea;
  int          n;
  int          k;
  assign a_bus  = a_oe ? a_o : bp_a;
  assign am_bus = am_oe ? am_o : bp_am;
  assign s_bus  = s_oe ? s_o : bp_s;
  always #4 clk_i = ~clk_i;
  always #7.8125 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////
  vpsc_top u_dut (
    .clk_i(clk_i), .rst_n_i(rst_n), .vme_reference_clock_i(ref_clk), .syscon_i(syscon), .mst_req_i(mreq),
    .mst_level_i(mlvl), .mst_addr_i(maddr), .mst_longword_n_i(mlw), .mst_space_i(mspace), .mst_super_i(msup),
    .mst_cycle_i(mcyc), .mst_program_i(mprog), .mst_write_i(mwr), .mst_rmw_i(mrmw), .mst_mblt_hi_i(mhi),
    .mst_iack_i(miack), .mst_iack_level_i(milvl), .mst_phase_done_i(mdone), .mst_last_i(mlast),
    .mst_owner_o(owner), .mst_strobe_o(strb), .slv_select_i(ssel), .slv_read_i(srd), .rx_addr_o(rxa),
    .rx_am_o(rxam), .rx_valid_o(rxv), .backplane_address_lines_i(a_bus), .backplane_address_lines_o(a_o),
    .backplane_address_lines_oe_o(a_oe), .longword_n_o(lw), .longword_n_oe_o(lw_oe),
    .address_modifier_lines_i(am_bus), .address_modifier_lines_o(am_o), .address_modifier_lines_oe_o(am_oe),
    .address_strobe_n_i(s_bus), .address_strobe_n_o(s_o), .address_strobe_n_oe_o(s_oe),
    .address_xcvr_direction_o(adir), .modifier_xcvr_direction_o(mdir), .strobe_xcvr_direction_o(sdir),
    .data_xcvr_direction_o(ddir), .bus_clear_n_o(bclr_n), .grant_in_n_i(gin_n), .grant_out_n_o(gout_n),
    .bus_request_n_i(req_n), .bus_busy_n_i(busy_n));
  vpsc_backplane u_bp (
    .clk_i(clk_i), .rst_n_i(rst_n), .grant_on_i(g_on), .grant_lvl_i(g_lvl), .req_on_i(r_on), .req_lvl_i(r_lvl),
    .busy_on_i(b_on), .fm_go_i(f_go), .fm_addr_i(f_addr), .fm_am_i(f_am), .bus_clear_n_i(bclr_n),
    .grant_in_n_o(gin_n), .bus_request_n_o(req_n), .bus_busy_n_o(busy_n), .addr_o(bp_a), .am_o(bp_am),
    .strobe_n_o(bp_s));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge clk_i);
    #1;
  endtask
  task automatic wait_val(input string what, ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      tick(1);
      n++;
    end
    check(what, s, v);
  endtask
  task automatic pulse(input logic l);
    @(posedge clk_i);
    mdone <= 1'b1;
    mlast <= l;
    @(posedge clk_i);
    mdone <= 1'b0;
    mlast <= 1'b0;
    tick(2);
  endtask
  function automatic logic [5:0] am_exp(logic [1:0] sp, logic su, logic [1:0] cy, logic pr);
    logic [2:0] hi;
    logic [1:0] lo;
    hi = (sp == vpsc_pkg::SPACE_A16) ? vpsc_pkg::AM_HI_A16 :
         (sp == vpsc_pkg::SPACE_A24) ? vpsc_pkg::AM_HI_A24 : vpsc_pkg::AM_HI_A32;
    lo = (cy == vpsc_pkg::CYC_MBLT) ? vpsc_pkg::AM_LO_MBLT : (cy == vpsc_pkg::CYC_BLOCK) ? vpsc_pkg::AM_LO_BLT :
         pr ? vpsc_pkg::AM_LO_PROG : vpsc_pkg::AM_LO_DATA;
    return {hi, su, lo};
  endfunction
  task automatic master_run(input logic [1:0] lv, input logic [1:0] sp, input logic [1:0] cy, input logic rw,
                            input logic ik);
    logic [31:1] ea;
    r = {$random(seed), $random(seed)};
    if (sp == vpsc_pkg::SPACE_A32 && cy == vpsc_pkg::CYC_SINGLE) r[6:5] = 2'h3; // corner: supervisor program
    @(posedge clk_i);
    {maddr, msup, mprog, mwr, milvl, mlw} <= r[37:0];
    mhi    <= r[62:32];
    mreq   <= 1'b1;
    mlvl   <= lv;
    mspace <= sp;
    mcyc   <= cy;
    mrmw   <= rw;
    miack  <= ik;
    g_on   <= 1'b1;
    g_lvl  <= lv;
    wait_val("owner", owner, 1'b1, 20);
    check("grant_out", gout_n, 4'hf);
    tick(1);
    ea = ik ? {maddr[31:4], milvl} : maddr;
    check("addr", a_bus, ea);
    check("am", am_bus, am_exp(sp, msup, cy, mprog));
    check("dirs", {adir, mdir, sdir, a_oe, am_oe, lw_oe, s_oe}, 7'h7f);
    check("lword", lw, mlw);
    check("data_dir", ddir, mwr);
    check("strobe_hi", s_bus, 1'b1);
    wait_val("strobe_lo", s_bus, 1'b0, 40);
    // lower bound only: first reference edge may come at once
    check("setup", n * 8000 >= (vpsc_pkg::ADDR_SETUP_REF - 1) * vpsc_pkg::REF_PERIOD_PS, 1'b1);
    check("addr_hold", a_bus, ea);
    if (cy == vpsc_pkg::CYC_MBLT) begin
      pulse(1'b0);
      check("mblt_hi", a_bus, mhi);
    end
    if (rw) begin
      pulse(1'b1);
      check("rmw_hold", {s_bus, strb}, 2'h1);
    end
    pulse(1'b1);
    check("released", {adir, mdir, sdir, ddir, a_oe, am_oe, lw_oe, s_oe, s_o, strb}, 10'h2);
    @(posedge clk_i);
    mreq <= 1'b0;
    g_on <= 1'b0;
    tick(8);
    check("owner_gone", owner, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    tick(1);
    check("reset", {adir, mdir, sdir, ddir, a_oe, am_oe, lw_oe, s_oe, owner, rxv, s_o, bclr_n, gout_n}, 16'h3f);
    tick(2);
    rst_n <= 1'b1;
    tick(10);
    for (k = 0; k < 4; k++) begin
      @(posedge clk_i);
      mreq  <= k[0];
      mlvl  <= 2'(k ^ 1);
      g_on  <= 1'b1;
      g_lvl <= 2'(k);
      tick(6);
      check("grant_pass", gout_n, 4'(~(4'h1 << k)));
      check("no_accept", owner, 1'b0);
      g_on <= 1'b0;
      tick(6);
      check("grant_back", gout_n, 4'hf);
    end
    $display("test grant_chain done");
    for (k = 0; k < 16; k++) begin
      master_run(2'($random(seed)), 2'(k), 2'(k >> 2), 1'b0, 1'b0);
    end
    master_run(2'h3, vpsc_pkg::SPACE_A24, vpsc_pkg::CYC_SINGLE, 1'b1, 1'b0);
    master_run(2'h0, vpsc_pkg::SPACE_A16, vpsc_pkg::CYC_SINGLE, 1'b0, 1'b1);
    $display("test master done");
    for (k = 0; k < 4; k++) begin
      r = {$random(seed), $random(seed)};
      @(posedge clk_i);
      f_addr <= r[30:0];
      f_am   <= r[37:32];
      f_go   <= 1'b1;
      ssel   <= 1'b1;
      srd    <= 1'b1;
      wait_val("rx_valid", rxv, 1'b1, 30);
      check("rx_addr", rxa, f_addr);
      check("rx_am", rxam, f_am);
      check("slave_dirs", {adir, mdir, sdir, ddir}, 4'h1);
      srd  <= 1'b0;
      f_go <= 1'b0;
      wait_val("rx_drop", rxv, 1'b0, 20);
      check("slave_wdir", ddir, 1'b0);
      ssel <= 1'b0;
    end
    $display("test slave done");
    @(posedge clk_i);
    g_on  <= 1'b1;
    g_lvl <= 2'h1;
    b_on  <= 1'b1;
    r_on  <= 1'b1;
    r_lvl <= 2'h3;
    tick(8);
    check("clear_no_syscon", bclr_n, 1'b1);
    g_on   <= 1'b0;
    r_lvl  <= 2'h1;
    // stale level 3 request must be gone before syscon
    tick(4);
    syscon <= 1'b1;
    tick(8);
    check("clear_equal", bclr_n, 1'b1);
    r_lvl <= 2'h3;
    wait_val("clear_low", bclr_n, 1'b0, 8);
    wait_val("busy_free", busy_n, 1'b1, 8);
    wait_val("clear_high", bclr_n, 1'b1, 8);
    $display("test bus_clear done");
    summarize();
  end
  initial begin
    #400000;
    err_count++;
    summarize();
  end
endmodule

// >>> sim/vpsc_backplane.sv
// Purpose : backplane partner: arbiter grants, requests, busy owner, foreign master
// Assumes : bench commands it; outputs move only at clk_i edges
// Notes   : released address and modifier lines toggle each cycle so a stale value never passes
`timescale 1ns/1ps
module vpsc_backplane (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        grant_on_i,
  input  wire logic [1:0]  grant_lvl_i,
  input  wire logic        req_on_i,
  input  wire logic [1:0]  req_lvl_i,
  input  wire logic        busy_on_i,
  input  wire logic        fm_go_i,
  input  wire logic [31:1] fm_addr_i,
  input  wire logic [5:0]  fm_am_i,
  input  wire logic        bus_clear_n_i,
  output logic [3:0]       grant_in_n_o,
  output logic [3:0]       bus_request_n_o,
  output logic             bus_busy_n_o,
  output logic [31:1]      addr_o,
  output logic [5:0]       am_o,
  output logic             strobe_n_o
);
  logic       busy_on_q;
  logic [1:0] cnt_q;
  ////////////////////////////////////////////////////////////
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      grant_in_n_o    <= 4'hf;
      bus_request_n_o <= 4'hf;
      bus_busy_n_o    <= 1'b1;
      busy_on_q       <= 1'b0;
      addr_o          <= '0;
      am_o            <= '0;
      strobe_n_o      <= 1'b1;
      cnt_q           <= '0;
    end else begin
      grant_in_n_o    <= grant_on_i ? 4'(~(4'h1 << grant_lvl_i)) : 4'hf;
      bus_request_n_o <= req_on_i ? 4'(~(4'h1 << req_lvl_i)) : 4'hf;
      busy_on_q       <= busy_on_i;
      // busy is taken once per command, so a release stays released
      if (!busy_on_i || !bus_clear_n_i) begin
        bus_busy_n_o <= 1'b1;
      end else if (!busy_on_q) begin
        bus_busy_n_o <= 1'b0;
      end
      if (fm_go_i) begin
        addr_o     <= fm_addr_i;
        am_o       <= fm_am_i;
        cnt_q      <= cnt_q + ((cnt_q != 2'h3) ? 2'h1 : 2'h0);
        strobe_n_o <= (cnt_q != 2'h3);
      end else begin
        addr_o     <= ~addr_o;
        am_o       <= ~am_o;
        cnt_q      <= '0;
        strobe_n_o <= 1'b1;
      end
    end
  end
endmodule
